// >>> verilog/i2ct_engine.sv
// Purpose: Byte-oriented I2C/SMBus target engine with AXI4-Lite registers.
// Assumes: Bus pins and the slow clock are asynchronous to aclk.
// Notes: All state freezes while clk_en is low.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module i2ct_engine
	import i2ct_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic scl_ext_low,
	output logic sda_ext_low,
	input wire logic slow_timeout_clock
);
	////////////////////////////////////////////////////////////////////////////
	logic [2:0] pin_in;
	logic [2:0] flt_q;
	logic [2:0] rise;
	logic [2:0] fall;
	assign pin_in = {slow_timeout_clock, sda_i, scl_i};
	// Each pin passes three stages; a change counts once stages two and three agree.
	for (genvar g = 0; g < 3; g++) begin : g_sync
		logic [2:0] sy_q;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sy_q <= 3'h7;
				flt_q[g] <= 1'b1;
			end else if (clk_en) begin
				sy_q <= {sy_q[1:0], pin_in[g]};
				if (sy_q[1] == sy_q[2])
					flt_q[g] <= sy_q[2];
			end
		end
		assign rise[g] = (sy_q[1] == sy_q[2]) && sy_q[2] && !flt_q[g];
		assign fall[g] = (sy_q[1] == sy_q[2]) && !sy_q[2] && flt_q[g];
	end
	logic scl_q, sda_q, scl_rise, scl_fall, slow_tick, start_det, stop_det;
	assign scl_q = flt_q[0];
	assign sda_q = flt_q[1];
	assign scl_rise = rise[0];
	assign scl_fall = fall[0];
	assign slow_tick = rise[2];
	assign start_det = fall[1] && scl_q;
	assign stop_det = rise[1] && scl_q;

	////////////////////////////////////////////////////////////////////////////
	logic [CW-1:0] ctrl_q;
	logic [9:0] own_q;
	logic ack_action_q, am_q, dr_q, pr_q, bus_clash_status_q, nack_q, dir_q, hs_q;
	logic lowto_q, sext_q, mext_q;
	logic [7:0] rx_q, sh_q;
	logic [3:0] bit_q;
	i2ct_state_t st_q, st_d;
	i2ct_ack_t kind_q, kind_d;
	logic ack_q, ack_d, a2_q, a2_d, hit10_q, hit10_d, seg_q, addr_q;
	logic set_am, set_dr, set_pr, set_bus_clash_status, set_nack, set_hs, ld_dir, dir_v;
	logic scl_hold_q, sda_low_q, abort;
	logic clock_stretch_mode_q, smart_q;
	assign clock_stretch_mode_q = ctrl_q[C_CLOCK_STRETCH_MODE];
	assign smart_q = ctrl_q[C_SMART];

	// AXI4-Lite slave: address and data taken in either order.
	logic aw_q, w_q, bvalid_q, rvalid_q, do_wr, ar_go;
	logic [AW-1:0] awa_q;
	logic [31:0] wd_q, wm_q, rdata_q, rd_mux;
	logic [1:0] bresp_q, rresp_q;
	logic rd_hit, wr_hit;
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready = !w_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign do_wr = aw_q && w_q && !bvalid_q;
	assign ar_go = s_axi_arvalid && !rvalid_q;
	assign wr_hit = (awa_q <= OFS_DATA) && (awa_q[1:0] == 2'h0);
	assign rd_hit = (s_axi_araddr <= OFS_DATA) && (s_axi_araddr[1:0] == 2'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			wm_q <= '0;
			bresp_q <= RESP_OK;
			rresp_q <= RESP_OK;
			rdata_q <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wd_q <= s_axi_wdata;
				wm_q <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end
			if (do_wr) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OK : RESP_ERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_go) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= rd_hit ? RESP_OK : RESP_ERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_mux = '0;
		if (s_axi_araddr == OFS_CTRL)
			rd_mux[CW-1:0] = ctrl_q;
		else if (s_axi_araddr == OFS_CMD)
			rd_mux[K_ACK_ACTION] = ack_action_q;
		else if (s_axi_araddr == OFS_FLAG)
			rd_mux[2:0] = {dr_q, am_q, pr_q};
		else if (s_axi_araddr == OFS_STAT)
			rd_mux[7:0] = {scl_hold_q, mext_q, sext_q, lowto_q, hs_q, dir_q, nack_q, bus_clash_status_q};
		else if (s_axi_araddr == OFS_ADDR)
			rd_mux[9:0] = own_q;
		else if (s_axi_araddr == OFS_DATA)
			rd_mux[7:0] = rx_q;
	end

	logic [31:0] wv;
	logic wr_ctrl, wr_cmd, wr_flag, wr_stat, wr_addr, wr_data;
	logic cmd_ack_p, cmd_wait_p, am_clr_p, dr_clr_p, data_rd_p, data_wr_p;
	assign wv = wd_q & wm_q;
	assign wr_ctrl = do_wr && awa_q == OFS_CTRL;
	assign wr_cmd = do_wr && awa_q == OFS_CMD && wm_q[0];
	assign wr_flag = do_wr && awa_q == OFS_FLAG;
	assign wr_stat = do_wr && awa_q == OFS_STAT;
	assign wr_addr = do_wr && awa_q == OFS_ADDR;
	assign wr_data = do_wr && awa_q == OFS_DATA && wm_q[0];
	assign cmd_ack_p = wr_cmd && wv[1:0] == CMD_ACK;
	assign cmd_wait_p = wr_cmd && wv[1:0] == CMD_WAIT;
	assign am_clr_p = wr_flag && wv[F_AM];
	assign dr_clr_p = wr_flag && wv[F_DR];
	assign data_rd_p = ar_go && s_axi_araddr == OFS_DATA;
	assign data_wr_p = wr_data && st_q == ST_THOLD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			own_q <= ADDR_RST;
			ack_action_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl)
				ctrl_q <= (ctrl_q & ~wm_q[CW-1:0]) | wv[CW-1:0];
			if (wr_addr)
				own_q <= (own_q & ~wm_q[9:0]) | wv[9:0];
			if (wr_cmd)
				ack_action_q <= wv[K_ACK_ACTION];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte sequencer.
	logic [7:0] b;
	logic ten_en, hdr10, mcode, match;
	assign b = sh_q;
	assign ten_en = ctrl_q[C_TEN];
	assign hdr10 = b[7:3] == TEN_HDR && b[2:1] == own_q[9:8];
	assign mcode = b[7:3] == MCODE_HDR && ctrl_q[C_SPD+1:C_SPD] == SPD_HS && clock_stretch_mode_q;

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		ack_d = ack_q;
		a2_d = a2_q;
		hit10_d = hit10_q;
		set_am = 1'b0;
		set_dr = 1'b0;
		set_pr = 1'b0;
		set_bus_clash_status = 1'b0;
		set_nack = 1'b0;
		set_hs = 1'b0;
		ld_dir = 1'b0;
		dir_v = b[0];
		match = 1'b0;
		if (!ctrl_q[C_EN] || abort) begin
			st_d = ST_IDLE;
		end else if (stop_det) begin
			if (ctrl_q[C_GROUP_COMMAND_ENABLE] && !ten_en)
				set_pr = addr_q;
			else
				set_pr = seg_q;
			st_d = ST_IDLE;
			hit10_d = 1'b0;
		end else if (start_det) begin
			st_d = ST_ADDR;
			a2_d = 1'b0;
		end else begin
			case (st_q)
				ST_ADDR: if (scl_fall && bit_q == 4'h8) begin
					if (ten_en && a2_q) begin
						match = b == own_q[7:0];
						dir_v = 1'b0;
						hit10_d = match;
					end else if (ten_en && hdr10 && b[0]) begin
						match = hit10_q;
					end else if (ten_en && hdr10) begin
						kind_d = AK_TEN1;
						ack_d = 1'b0;
						st_d = ST_ACK;
					end else if (!ten_en) begin
						match = b[7:1] == own_q[6:0];
					end
					if (mcode && !match) begin
						set_hs = 1'b1;
						st_d = ST_IDLE;
					end else if (match) begin
						ld_dir = 1'b1;
						kind_d = AK_ADDR;
						ack_d = ack_action_q;
						set_am = !clock_stretch_mode_q;
						st_d = clock_stretch_mode_q ? ST_ACK : ST_AHOLD;
					end else if (st_d == ST_ADDR) begin
						st_d = ST_IDLE;
					end
				end
				ST_AHOLD: if (cmd_ack_p || am_clr_p) begin
					st_d = ST_ACK;
				end
				ST_ACK: if (scl_fall) begin
					if (kind_q == AK_TEN1) begin
						st_d = ST_ADDR;
						a2_d = 1'b1;
					end else if (ack_q) begin
						set_am = kind_q == AK_ADDR && clock_stretch_mode_q;
						st_d = ST_IDLE;
					end else if (kind_q == AK_ADDR) begin
						set_am = clock_stretch_mode_q;
						set_dr = dir_q;
						st_d = dir_q ? ST_THOLD : (clock_stretch_mode_q ? ST_PHOLD : ST_RX);
					end else begin
						set_dr = clock_stretch_mode_q;
						st_d = clock_stretch_mode_q ? ST_PHOLD : ST_RX;
					end
				end
				ST_RX: if (scl_fall && bit_q == 4'h8) begin
					kind_d = AK_DATA;
					ack_d = ack_action_q;
					set_dr = !clock_stretch_mode_q;
					st_d = clock_stretch_mode_q ? ST_ACK : ST_RHOLD;
				end
				ST_RHOLD: if (cmd_ack_p || dr_clr_p || (smart_q && data_rd_p)) begin
					st_d = ST_ACK;
				end
				ST_PHOLD: if (!am_q && !dr_q) begin
					st_d = ST_RX;
				end
				ST_THOLD: if (data_wr_p) begin
					st_d = ST_TX;
				end
				ST_TX: if (scl_rise && !sda_low_q && !sda_q) begin
					set_bus_clash_status = 1'b1;
					st_d = ST_IDLE;
				end else if (scl_fall && bit_q == 4'h7) begin
					st_d = ST_TACK;
				end
				ST_TACK: if (scl_rise) begin
					set_nack = sda_q;
				end else if (scl_fall) begin
					set_dr = !nack_q;
					st_d = nack_q ? ST_IDLE : ST_THOLD;
				end
				default: st_d = st_q;
			endcase
			if (cmd_wait_p && st_d != ST_TX && st_d != ST_TACK)
				st_d = ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			kind_q <= AK_ADDR;
			ack_q <= 1'b0;
			a2_q <= 1'b0;
			hit10_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			kind_q <= kind_d;
			ack_q <= ack_d;
			a2_q <= a2_d;
			hit10_q <= hit10_d;
		end
	end

	// Shift register: capture on SCL rise, send on SCL fall.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_q <= '0;
			bit_q <= '0;
			rx_q <= '0;
		end else if (clk_en) begin
			if (st_d == ST_TX && st_q != ST_TX) begin
				sh_q <= wv[7:0];
				bit_q <= '0;
			end else if (st_q == ST_TX && scl_fall) begin
				sh_q <= {sh_q[6:0], 1'b0};
				bit_q <= bit_q + 4'h1;
			end else if ((st_d == ST_ADDR || st_d == ST_RX) && st_d != st_q) begin
				bit_q <= '0;
			end else if ((st_q == ST_ADDR || st_q == ST_RX) && scl_rise) begin
				sh_q <= {sh_q[6:0], sda_q};
				bit_q <= bit_q + 4'h1;
			end
			if (st_q == ST_RX && scl_fall && bit_q == 4'h8)
				rx_q <= sh_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags and status; a hardware set wins over a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			am_q <= 1'b0;
			dr_q <= 1'b0;
			pr_q <= 1'b0;
			bus_clash_status_q <= 1'b0;
			nack_q <= 1'b0;
			dir_q <= 1'b0;
			hs_q <= 1'b0;
			seg_q <= 1'b0;
			addr_q <= 1'b0;
		end else if (clk_en) begin
			am_q <= set_am || (am_q && !am_clr_p && !(cmd_ack_p && st_q == ST_AHOLD));
			dr_q <= set_dr || (dr_q && !dr_clr_p && !data_wr_p && !(smart_q && data_rd_p));
			pr_q <= set_pr || (pr_q && !(wr_flag && wv[F_STOP_RECEIVED_FLAG]));
			bus_clash_status_q <= set_bus_clash_status || (bus_clash_status_q && !(wr_stat && wv[S_BUS_CLASH_STATUS]));
			if (ld_dir)
				dir_q <= dir_v;
			if (st_q == ST_TACK && scl_rise)
				nack_q <= set_nack;
			hs_q <= set_hs || (hs_q && !stop_det);
			seg_q <= ld_dir || (seg_q && !start_det && !stop_det);
			addr_q <= ld_dir || (addr_q && !stop_det);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// SMBus time-outs, counted on slow clock edges.
	logic [TW-1:0] low_c, sext_c, mext_c;
	assign abort = ctrl_q[C_LOWTO] && slow_tick && low_c == LOW_TICKS - 1'b1;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_c <= '0;
			sext_c <= '0;
			mext_c <= '0;
			lowto_q <= 1'b0;
			sext_q <= 1'b0;
			mext_q <= 1'b0;
		end else if (clk_en) begin
			if (scl_q || abort)
				low_c <= '0;
			else if (slow_tick)
				low_c <= low_c + 1'b1;
			if (stop_det)
				sext_c <= '0;
			else if (slow_tick && scl_hold_q && sext_c != SEXT_TICKS)
				sext_c <= sext_c + 1'b1;
			if (start_det || stop_det || (scl_fall && (st_q == ST_ACK || st_q == ST_TACK)))
				mext_c <= '0;
			else if (slow_tick && !scl_q && !scl_hold_q && mext_c != MEXT_TICKS)
				mext_c <= mext_c + 1'b1;
			lowto_q <= abort || (lowto_q && !(wr_stat && wv[S_LOWTO]));
			sext_q <= (ctrl_q[C_SEXT] && sext_c == SEXT_TICKS) ||
				(sext_q && !(wr_stat && wv[S_SEXT]));
			mext_q <= (ctrl_q[C_MEXT] && mext_c == MEXT_TICKS) ||
				(mext_q && !(wr_stat && wv[S_MEXT]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line drivers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_hold_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (clk_en) begin
			scl_hold_q <= st_q == ST_AHOLD || st_q == ST_RHOLD || st_q == ST_PHOLD ||
				st_q == ST_THOLD;
			sda_low_q <= (st_q == ST_ACK && !ack_q) || (st_q == ST_TX && !sh_q[7]) ||
				(st_q == ST_THOLD && st_d == ST_TX && !wv[7]);
		end
	end
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = ctrl_q[C_4W] || !scl_hold_q;
	assign sda_oe_n = ctrl_q[C_4W] || !sda_low_q;
	assign scl_ext_low = ctrl_q[C_4W] && scl_hold_q;
	assign sda_ext_low = ctrl_q[C_4W] && sda_low_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence released_s;
		st_q == ST_IDLE ##1 (!scl_hold_q && !sda_low_q);
	endsequence
	address_match_flag_hold_a: assert property (
		(st_q == ST_AHOLD && $past(st_q) == ST_AHOLD) |-> scl_hold_q)
		else $error("SCL not held during address hold");
	dir_stable_a: assert property (
		(clk_en && !ld_dir) |=> dir_q == $past(dir_q))
		else $error("Direction changed without a match");
	pre_ack_hold_a: assert property (
		$rose(st_q == ST_AHOLD) |-> $past(!clock_stretch_mode_q) && am_q)
		else $error("Pre-ack hold in wrong stretch mode");
	post_ack_flag_a: assert property (
		($rose(am_q) && $past(clock_stretch_mode_q)) |-> $past(st_q) == ST_ACK)
		else $error("Address flag raised before the ack");
	stop_idle_a: assert property (
		(clk_en && stop_det && ctrl_q[C_EN]) |=> st_q == ST_IDLE)
		else $error("Stop did not return to idle");
	nack_release_a: assert property (
		(clk_en && st_q == ST_TACK && scl_fall && nack_q) |=> released_s)
		else $error("SDA not released after nack");
	clash_release_a: assert property (
		(clk_en && set_bus_clash_status) |=> bus_clash_status_q ##0 released_s)
		else $error("Collision did not release the lines");
	ack_cmd_a: assert property (
		(clk_en && st_q == ST_AHOLD && cmd_ack_p && ctrl_q[C_EN] && !abort &&
		!stop_det && !start_det) |=> st_q == ST_ACK && ack_q == $past(ack_q))
		else $error("Ack command did not start the ack bit");
	smart_ack_a: assert property (
		(clk_en && st_q == ST_RHOLD && data_rd_p && smart_q && ctrl_q[C_EN] &&
		!abort && !stop_det && !start_det) |=> st_q == ST_ACK)
		else $error("Smart read did not send the ack");
endmodule : i2ct_engine
`default_nettype wire

// >>> verilog/i2ct_pkg.sv
// Purpose: Shared constants and types of the I2C target engine.
// Assumes: Registers are reached over a 32-bit AXI4-Lite slave.
// Notes: Bus time-outs count rising edges of the slow time-out clock.
`default_nettype none
package i2ct_pkg;
	localparam int AW = 8;
	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_CMD = 8'h04;
	localparam logic [AW-1:0] OFS_FLAG = 8'h08;
	localparam logic [AW-1:0] OFS_STAT = 8'h0C;
	localparam logic [AW-1:0] OFS_ADDR = 8'h10;
	localparam logic [AW-1:0] OFS_DATA = 8'h14;
	// Control word fields.
	localparam int C_EN = 0;
	localparam int C_CLOCK_STRETCH_MODE = 1;
	localparam int C_SMART = 2;
	localparam int C_4W = 3;
	localparam int C_SPD = 4;
	localparam int C_LOWTO = 6;
	localparam int C_SEXT = 7;
	localparam int C_MEXT = 8;
	localparam int C_GROUP_COMMAND_ENABLE = 9;
	localparam int C_TEN = 10;
	localparam int CW = 11;
	localparam logic [CW-1:0] CTRL_RST = 11'h000;
	localparam logic [9:0] ADDR_RST = 10'h000;
	// Command word, flag and status fields.
	localparam int K_ACK_ACTION = 2;
	localparam int F_STOP_RECEIVED_FLAG = 0;
	localparam int F_AM = 1;
	localparam int F_DR = 2;
	localparam int S_BUS_CLASH_STATUS = 0;
	localparam int S_NACK = 1;
	localparam int S_DIR = 2;
	localparam int S_HS = 3;
	localparam int S_LOWTO = 4;
	localparam int S_SEXT = 5;
	localparam int S_MEXT = 6;
	localparam int S_HOLD = 7;
	localparam logic [1:0] CMD_WAIT = 2'h2;
	localparam logic [1:0] CMD_ACK = 2'h3;
	localparam logic [1:0] SPD_HS = 2'h2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [4:0] TEN_HDR = 5'h1E;
	localparam logic [4:0] MCODE_HDR = 5'h01;
	// Time-outs, in slow clock edges, rounded up.
	localparam int SLOW_HZ = 32768;
	localparam int LOW_MS = 25;
	localparam int SEXT_MS = 25;
	localparam int MEXT_MS = 10;
	localparam int TW = 11;
	localparam logic [TW-1:0] LOW_TICKS = TW'((LOW_MS * SLOW_HZ + 999) / 1000);
	localparam logic [TW-1:0] SEXT_TICKS = TW'((SEXT_MS * SLOW_HZ + 999) / 1000);
	localparam logic [TW-1:0] MEXT_TICKS = TW'((MEXT_MS * SLOW_HZ + 999) / 1000);
	typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_AHOLD, ST_ACK, ST_RX, ST_RHOLD,
		ST_PHOLD, ST_THOLD, ST_TX, ST_TACK} i2ct_state_t;
	typedef enum logic [1:0] {AK_ADDR, AK_DATA, AK_TEN1} i2ct_ack_t;
endpackage : i2ct_pkg
`default_nettype wire

// >>> bench/i2ct_host_model.sv
// Purpose: Behavioural I2C host that clocks frames onto the two bus lines.
// Assumes: Lines are pulled up; a pull output of one drives the line low.
// Notes: SCL stands high between frames; tasks are called from the bench.
`timescale 1ns/100ps
`default_nettype none
module i2ct_host_model (
	input wire logic scl_line,
	input wire logic sda_line,
	output logic scl_pull,
	output logic sda_pull
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Releases SCL and waits, bounded, while the target stretches it.
	task automatic scl_up();
		int n;
		n = 0;
		scl_pull = 1'b0;
		while (scl_line !== 1'b1 && n < 20000) begin
			#10;
			n++;
		end
	endtask : scl_up
	task automatic start();
		sda_pull = 1'b1;
		#62.5;
		scl_pull = 1'b1;
		#40;
	endtask : start
	// A bit lasts 85 ns low and 40 ns high; SDA is sampled just before the fall.
	task automatic clk_bit(input logic b, output logic r);
		sda_pull = !b;
		#45;
		scl_up();
		#40;
		r = sda_line;
		scl_pull = 1'b1;
		#40;
	endtask : clk_bit
	task automatic send_bits(input logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(v[i], r);
		end
	endtask : send_bits
	task automatic recv_bits(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			v[i] = r;
		end
	endtask : recv_bits
	task automatic stop();
		sda_pull = 1'b1;
		#45;
		scl_up();
		#62.5;
		sda_pull = 1'b0;
		#62.5;
	endtask : stop
endmodule : i2ct_host_model
`default_nettype wire

// >>> bench/i2c_target_engine_test.sv
// Purpose: Self-checking bench of the I2C target engine.
// Assumes: One host model on the bus; registers reached over AXI4-Lite.
// Notes: Time-outs are too long to reach; the slow clock still runs.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("FAIL %0t got %h want %h", $time, (got), (exp)); \
	end \
end
module i2c_target_engine_test
	import i2ct_pkg::*;
;
	typedef struct packed {logic [AW-1:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] s;} i2ct_row_t;
	localparam i2ct_row_t ROWS [5] = '{
		'{OFS_ADDR, 32'hFFFF_FFFF, 32'h0000_03FF, RESP_OK},
		'{OFS_CTRL, 32'h0000_07FF, 32'h0000_07FF, RESP_OK},
		'{OFS_CMD, 32'h0000_0007, 32'h0000_0004, RESP_OK},
		'{OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OK},
		'{8'h18, 32'h0000_00FF, 32'h0000_0000, RESP_ERR}};
	logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, slow_clk = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_ext_low, sda_ext_low;
	logic host_scl, host_sda;
	wire scl_line = !(host_scl || !scl_oe_n || scl_ext_low);
	wire sda_line = !(host_sda || !sda_oe_n || sda_ext_low);
	logic [10:0] slow_cnt = '0;
	int failures = 0;
	int n_tests = 0;
	always #5 aclk = !aclk;
	always @(posedge aclk) begin
		slow_cnt <= (slow_cnt == 11'd1525) ? '0 : slow_cnt + 11'd1;
		slow_clk <= (slow_cnt == 11'd1525) ? !slow_clk : slow_clk;
	end
	i2ct_engine dut (.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .scl_i(scl_line), .scl_o, .scl_oe_n,
		.sda_i(sda_line), .sda_o, .sda_oe_n, .scl_ext_low, .sda_ext_low,
		.slow_timeout_clock(slow_clk));
	i2ct_host_model host (.scl_line, .sda_line, .scl_pull(host_scl), .sda_pull(host_sda));
	////////////////////////////////////////////////////////////////////////////////
	task automatic axi_wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] s);
		int n;
		bit a_ok, w_ok;
		n = 0;
		a_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		while (!(a_ok && w_ok) && n < 50) begin
			@(posedge aclk);
			n++;
			if (!a_ok && s_axi_awready === 1'b1) begin
				a_ok = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 100)
			failures++;
		s = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] s);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 50);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		if (n >= 100)
			failures++;
		d = s_axi_rdata;
		s = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		logic [1:0] s;
		axi_wr(a, d, s);
	endtask : wr
	task automatic chk(input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] s;
		axi_rd(a, d, s);
		`CHK(d & m, e)
	endtask : chk
	task automatic settle();
		repeat (20) @(posedge aclk);
	endtask : settle
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0] s;
		logic r;
		logic [7:0] b;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
		chk(OFS_FLAG, 32'hFFFF_FFFF, 32'h0);
		$display("test reset done");
		foreach (ROWS[i]) begin
			axi_wr(ROWS[i].a, ROWS[i].w, s);
			`CHK(s, ROWS[i].s)
			axi_rd(ROWS[i].a, d, s);
			`CHK(d, ROWS[i].r)
			`CHK(s, ROWS[i].s)
		end
		$display("test registers done");
		wr(OFS_CMD, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_ADDR, 32'h2A);
		host.start();
		host.send_bits(8'h54);
		settle();
		`CHK(scl_oe_n, 1'b0)
		chk(OFS_FLAG, 32'h7, 32'h2);
		chk(OFS_STAT, 32'h4, 32'h0);
		wr(OFS_FLAG, 32'h2);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b0)
		host.send_bits(8'hA5);
		settle();
		chk(OFS_FLAG, 32'h4, 32'h4);
		chk(OFS_DATA, 32'hFF, 32'hA5);
		wr(OFS_CMD, 32'h3);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b0)
		host.stop();
		settle();
		chk(OFS_FLAG, 32'h1, 32'h1);
		wr(OFS_FLAG, 32'h7);
		$display("test host write done");
		host.start();
		host.send_bits(8'h56);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b1)
		host.stop();
		settle();
		chk(OFS_FLAG, 32'h7, 32'h0);
		$display("test mismatch done");
		host.start();
		host.send_bits(8'h55);
		settle();
		chk(OFS_STAT, 32'h4, 32'h4);
		wr(OFS_CMD, 32'h3);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b0)
		settle();
		chk(OFS_FLAG, 32'h4, 32'h4);
		wr(OFS_DATA, 32'hC3);
		host.recv_bits(b);
		`CHK(b, 8'hC3)
		host.clk_bit(1'b1, r);
		settle();
		chk(OFS_STAT, 32'h2, 32'h2);
		`CHK(sda_oe_n, 1'b1)
		host.stop();
		settle();
		chk(OFS_FLAG, 32'h1, 32'h1);
		wr(OFS_FLAG, 32'h7);
		$display("test host read done");
		wr(OFS_CTRL, 32'hF);
		host.start();
		host.send_bits(8'h54);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b0)
		settle();
		chk(OFS_FLAG, 32'h7, 32'h2);
		`CHK(scl_ext_low, 1'b1)
		`CHK(scl_oe_n, 1'b1)
		wr(OFS_FLAG, 32'h2);
		host.send_bits(8'h5A);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b0)
		settle();
		chk(OFS_FLAG, 32'h4, 32'h4);
		wr(OFS_CMD, 32'h4);
		chk(OFS_DATA, 32'hFF, 32'h5A);
		host.send_bits(8'h11);
		host.clk_bit(1'b1, r);
		`CHK(r, 1'b1)
		wr(OFS_FLAG, 32'h6);
		host.stop();
		settle();
		chk(OFS_FLAG, 32'h1, 32'h1);
		$display("test stretch mode one done");
		s_axi_wstrb <= 4'h0;
		wr(OFS_CMD, 32'h0);
		s_axi_wstrb <= 4'hF;
		chk(OFS_CMD, 32'h4, 32'h4);
		clk_en <= 1'b0;
		host.start();
		host.send_bits(8'h54);
		clk_en <= 1'b1;
		settle();
		chk(OFS_FLAG, 32'h2, 32'h0);
		host.stop();
		settle();
		chk(OFS_STAT, 32'h80, 32'h0);
		$display("test strobe and freeze done");
		wrap_up();
	end
endmodule : i2c_target_engine_test
`default_nettype wire
